/* File: rtl/cvmc_regs.svh */
// Register offsets, field positions, reset values and counts of the
// channel volume and mute control bank. Definitions only.
// How it works
// - Bit 4 picks TDM slot: 32/16 cycles
// - Bit 3 inverts every output polarity
// - Automute channel after 1024 consecutive zero samples
// - Bit 1 picks oversampling: 256x or 128x
// - Control two at 0x08, resets 0x06
// - Mute low bits mute channels 8..1
// - Mute high bits 3..0 mute channels 12..9
// - Attenuation codes 8-bit, 0.375 dB per step
// - Master attenuation applies to all channels
// - Channels 1..3 attenuation at 0x0C upward
`ifndef CVMC_REGS_SVH
`define CVMC_REGS_SVH

// ==========================================================
// Offsets
`define CVMC_OFF_CTRL_TWO 8'h08
`define CVMC_OFF_MUTE_LOW 8'h09
`define CVMC_OFF_MUTE_HIGH 8'h0a
`define CVMC_OFF_MASTER_ATT 8'h0b
`define CVMC_OFF_CH1_ATT 8'h0c
`define CVMC_OFF_CH2_ATT 8'h0d
`define CVMC_OFF_CH3_ATT 8'h0e

// ==========================================================
// Fields of converter_control_two
`define CVMC_BIT_SLOT_WIDTH 4
`define CVMC_BIT_POL_INVERT 3
`define CVMC_BIT_AUTOMUTE_EN 2
`define CVMC_BIT_OSR_SELECT 1
`define CVMC_BIT_DEEMPH_EN 0
`define CVMC_CTRL_TWO_MASK 8'h1f
`define CVMC_MUTE_HIGH_MASK 8'h0f

// ==========================================================
// Reset values
`define CVMC_RST_CTRL_TWO 8'h06
`define CVMC_RST_MUTE 8'h00
`define CVMC_RST_ATT 8'h00

// ==========================================================
// Counts
`define CVMC_AUTOMUTE_ZEROS 11'h400
`define CVMC_SLOT_CYC_WIDE 6'h20
`define CVMC_SLOT_CYC_NARROW 6'h10
`define CVMC_OSR_LOW 9'h100
`define CVMC_OSR_HIGH 9'h080
`define CVMC_ATT_FULL 8'hff
`define CVMC_NUM_CH 12

`endif

/* File: rtl/cvmc_pkg.sv */
// Types shared by the channel volume and mute control bank.
// Assumes the constants header is compiled alongside.
package cvmc_pkg;
    typedef logic [7:0] cvmc_byte_t;
    typedef logic [3:0] cvmc_chan_t;
    typedef logic [23:0] cvmc_sample_t;
    typedef logic [11:0] cvmc_chmask_t;
endpackage

/* File: rtl/cvmc_smp_if.sv */
// Carrier between the main bank and the zero-input detector.
// Assumes both ends share sys_clk.
`timescale 1ns/10ps
interface cvmc_smp_if;
    logic smp_valid;
    logic [3:0] smp_chan;
    logic smp_zero;
    logic automute_en;
    logic [11:0] auto_muted;
    modport bank (output smp_valid, output smp_chan, output smp_zero,
        output automute_en, input auto_muted);
    modport det (input smp_valid, input smp_chan, input smp_zero,
        input automute_en, output auto_muted);
endinterface

/* File: rtl/cvmc_zero_det.sv */
// Per-channel run counters of zero-valued input samples.
// Assumes samples arrive tagged with a channel index below twelve.
`timescale 1ns/10ps
`include "cvmc_regs.svh"
module cvmc_zero_det (
    input wire logic sys_clk, // System clock
    input wire logic rst_b, // Synchronous reset, active low
    cvmc_smp_if.det smp // Sample tags in, automute flags out
);
    import cvmc_pkg::*;

    logic [10:0] run_reg [`CVMC_NUM_CH];
    logic [10:0] run_next [`CVMC_NUM_CH];
    cvmc_chmask_t muted_reg;
    cvmc_chmask_t muted_next;

    // ==========================================================
    // Run counters saturate so a long silence never wraps to unmuted
    genvar g;
    generate
        for (g = 0; g < `CVMC_NUM_CH; g = g + 1) begin : g_ch
            always_comb begin
                run_next[g] = run_reg[g];
                if (smp.smp_valid && smp.smp_chan == 4'(g)) begin
                    if (!smp.smp_zero) begin
                        run_next[g] = 11'h000;
                    end else if (run_reg[g] != `CVMC_AUTOMUTE_ZEROS) begin
                        run_next[g] = run_reg[g] + 11'h001;
                    end
                end
            end

            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    run_reg[g] <= 11'h000;
                end else begin
                    run_reg[g] <= run_next[g];
                end
            end
        end
    endgenerate

    // Each channel mutes on its own run
    // One process owns the whole mask, so no bit has two writers
    always_comb begin
        for (int i = 0; i < `CVMC_NUM_CH; i++) begin
            muted_next[i] = smp.automute_en && (run_next[i] == `CVMC_AUTOMUTE_ZEROS);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            muted_reg <= 12'h000;
        end else begin
            muted_reg <= muted_next;
        end
    end

    assign smp.auto_muted = muted_reg;
endmodule

/* File: rtl/cvmc_top.sv */
// Control register bank for the twelve-channel converter: slot width,
// polarity, automute, oversampling, de-emphasis, soft mutes, attenuation.
// Assumes the serial control front end hands over decoded byte
// accesses on sys_clk, and samples come from logic on the same clock.
`timescale 1ns/10ps
`include "cvmc_regs.svh"
module cvmc_top (
    input wire logic sys_clk, // 125 MHz system clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    input wire cvmc_pkg::cvmc_byte_t reg_addr, // Register address
    input wire cvmc_pkg::cvmc_byte_t reg_wdata, // Write data
    output cvmc_pkg::cvmc_byte_t reg_rdata, // Read data
    output logic reg_rvalid, // Read data valid pulse
    input wire logic smp_in_valid, // Input sample strobe
    input wire cvmc_pkg::cvmc_chan_t smp_in_chan, // Channel index 0..11
    input wire cvmc_pkg::cvmc_sample_t smp_in_data, // Signed sample
    output logic smp_out_valid, // Output sample strobe
    output cvmc_pkg::cvmc_chan_t smp_out_chan, // Output channel index
    output cvmc_pkg::cvmc_sample_t smp_out_data, // Sample after polarity and mute
    output logic [5:0] slot_bclk_cycles, // Bit clocks per TDM slot
    output logic [8:0] osr_ratio, // Oversampling ratio
    output logic deemphasis_enable, // De-emphasis on
    output logic output_polarity_invert, // Global polarity inversion
    output cvmc_pkg::cvmc_chmask_t chan_mute, // Soft, auto or full mute per channel
    output cvmc_pkg::cvmc_byte_t master_atten, // Master code, channels 4..12
    output cvmc_pkg::cvmc_byte_t ch1_eff_atten, // Effective code, channel 1
    output cvmc_pkg::cvmc_byte_t ch2_eff_atten, // Effective code, channel 2
    output cvmc_pkg::cvmc_byte_t ch3_eff_atten // Effective code, channel 3
);
    import cvmc_pkg::*;

    // Nine-bit sum of master and channel codes, carry kept for att_clip
    function automatic logic [8:0] att_sum(input cvmc_byte_t m, input cvmc_byte_t c);
        att_sum = {1'b0, m} + {1'b0, c};
    endfunction

    function automatic cvmc_byte_t att_clip(input logic [8:0] s);
        att_clip = s[8] ? `CVMC_ATT_FULL : s[7:0];
    endfunction

    // ==========================================================
    // Register file
    cvmc_byte_t ctrl_two_reg, ctrl_two_next;
    cvmc_byte_t mute_low_reg, mute_low_next;
    cvmc_byte_t mute_high_reg, mute_high_next;
    cvmc_byte_t master_reg, master_next;
    cvmc_byte_t ch1_reg, ch1_next;
    cvmc_byte_t ch2_reg, ch2_next;
    cvmc_byte_t ch3_reg, ch3_next;
    cvmc_byte_t rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    always_comb begin
        ctrl_two_next = ctrl_two_reg;
        mute_low_next = mute_low_reg;
        mute_high_next = mute_high_reg;
        master_next = master_reg;
        ch1_next = ch1_reg;
        ch2_next = ch2_reg;
        ch3_next = ch3_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                `CVMC_OFF_CTRL_TWO: ctrl_two_next = reg_wdata & `CVMC_CTRL_TWO_MASK;
                `CVMC_OFF_MUTE_LOW: mute_low_next = reg_wdata;
                `CVMC_OFF_MUTE_HIGH: mute_high_next = reg_wdata & `CVMC_MUTE_HIGH_MASK;
                `CVMC_OFF_MASTER_ATT: master_next = reg_wdata;
                `CVMC_OFF_CH1_ATT: ch1_next = reg_wdata;
                `CVMC_OFF_CH2_ATT: ch2_next = reg_wdata;
                `CVMC_OFF_CH3_ATT: ch3_next = reg_wdata;
                default: ;
            endcase
        end
        // Unmapped addresses read as zero
        rvalid_next = reg_rd;
        rdata_next = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `CVMC_OFF_CTRL_TWO: rdata_next = ctrl_two_reg;
                `CVMC_OFF_MUTE_LOW: rdata_next = mute_low_reg;
                `CVMC_OFF_MUTE_HIGH: rdata_next = mute_high_reg;
                `CVMC_OFF_MASTER_ATT: rdata_next = master_reg;
                `CVMC_OFF_CH1_ATT: rdata_next = ch1_reg;
                `CVMC_OFF_CH2_ATT: rdata_next = ch2_reg;
                `CVMC_OFF_CH3_ATT: rdata_next = ch3_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl_two_reg <= `CVMC_RST_CTRL_TWO;
            mute_low_reg <= `CVMC_RST_MUTE;
            mute_high_reg <= `CVMC_RST_MUTE;
            master_reg <= `CVMC_RST_ATT;
            ch1_reg <= `CVMC_RST_ATT;
            ch2_reg <= `CVMC_RST_ATT;
            ch3_reg <= `CVMC_RST_ATT;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            ctrl_two_reg <= ctrl_two_next;
            mute_low_reg <= mute_low_next;
            mute_high_reg <= mute_high_next;
            master_reg <= master_next;
            ch1_reg <= ch1_next;
            ch2_reg <= ch2_next;
            ch3_reg <= ch3_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ==========================================================
    // Zero-input detector
    cvmc_smp_if smp_bus ();
    assign smp_bus.smp_valid = smp_in_valid;
    assign smp_bus.smp_chan = smp_in_chan;
    assign smp_bus.smp_zero = (smp_in_data == 24'h000000);
    assign smp_bus.automute_en = ctrl_two_reg[`CVMC_BIT_AUTOMUTE_EN];

    cvmc_zero_det u_zero_det (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .smp(smp_bus.det)
    );

    // ==========================================================
    // Derived settings, all registered
    logic [8:0] sum1, sum2, sum3;
    cvmc_chmask_t full_mute;
    cvmc_chmask_t mute_next;
    logic [5:0] slot_next;
    logic [8:0] osr_next;

    always_comb begin
        sum1 = att_sum(master_reg, ch1_reg);
        sum2 = att_sum(master_reg, ch2_reg);
        sum3 = att_sum(master_reg, ch3_reg);
        // Past the bottom of the code range the channel is simply muted
        full_mute = {9'h000, sum3[8], sum2[8], sum1[8]};
        mute_next = {mute_high_reg[3:0], mute_low_reg}
            | smp_bus.auto_muted | full_mute;
        slot_next = ctrl_two_reg[`CVMC_BIT_SLOT_WIDTH] ? `CVMC_SLOT_CYC_NARROW
            : `CVMC_SLOT_CYC_WIDE;
        osr_next = ctrl_two_reg[`CVMC_BIT_OSR_SELECT] ? `CVMC_OSR_HIGH
            : `CVMC_OSR_LOW;
    end

    cvmc_chmask_t mute_reg;
    logic [5:0] slot_reg;
    logic [8:0] osr_reg;
    logic pol_reg, deemph_reg;
    cvmc_byte_t e1_reg, e2_reg, e3_reg, mst_out_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mute_reg <= 12'h000;
            slot_reg <= `CVMC_SLOT_CYC_WIDE;
            osr_reg <= `CVMC_OSR_HIGH;
            pol_reg <= 1'b0;
            deemph_reg <= 1'b0;
            e1_reg <= `CVMC_RST_ATT;
            e2_reg <= `CVMC_RST_ATT;
            e3_reg <= `CVMC_RST_ATT;
            mst_out_reg <= `CVMC_RST_ATT;
        end else begin
            mute_reg <= mute_next;
            slot_reg <= slot_next;
            osr_reg <= osr_next;
            pol_reg <= ctrl_two_reg[`CVMC_BIT_POL_INVERT];
            deemph_reg <= ctrl_two_reg[`CVMC_BIT_DEEMPH_EN];
            e1_reg <= att_clip(sum1);
            e2_reg <= att_clip(sum2);
            e3_reg <= att_clip(sum3);
            mst_out_reg <= master_reg;
        end
    end

    // ==========================================================
    // Sample path: polarity then mute
    logic sv_reg, sv_next;
    cvmc_chan_t sc_reg, sc_next;
    cvmc_sample_t sd_reg, sd_next;
    cvmc_sample_t inv;

    always_comb begin
        // Negating the most negative code would overflow, so clamp it
        inv = (smp_in_data == 24'h800000) ? 24'h7fffff : 24'(-smp_in_data);
        sv_next = smp_in_valid;
        sc_next = smp_in_chan;
        sd_next = ctrl_two_reg[`CVMC_BIT_POL_INVERT] ? inv : smp_in_data;
        if (smp_in_chan < 4'hc && mute_next[smp_in_chan]) begin
            sd_next = 24'h000000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sv_reg <= 1'b0;
            sc_reg <= 4'h0;
            sd_reg <= 24'h000000;
        end else begin
            sv_reg <= sv_next;
            sc_reg <= sc_next;
            sd_reg <= sd_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign smp_out_valid = sv_reg;
    assign smp_out_chan = sc_reg;
    assign smp_out_data = sd_reg;
    assign slot_bclk_cycles = slot_reg;
    assign osr_ratio = osr_reg;
    assign deemphasis_enable = deemph_reg;
    assign output_polarity_invert = pol_reg;
    assign chan_mute = mute_reg;
    assign master_atten = mst_out_reg;
    assign ch1_eff_atten = e1_reg;
    assign ch2_eff_atten = e2_reg;
    assign ch3_eff_atten = e3_reg;
endmodule

/* File: test/cvmc_sva.sv */
// Port checker for the volume and mute control bank.
// Assumes it is bound into cvmc_top and shares its clock and reset.
`timescale 1ns/10ps
module cvmc_sva (
    input wire logic sys_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire cvmc_pkg::cvmc_byte_t reg_addr, // Address
    input wire cvmc_pkg::cvmc_byte_t reg_wdata, // Write data
    input wire cvmc_pkg::cvmc_byte_t reg_rdata, // Read data
    input wire logic reg_rvalid, // Read valid
    input wire logic smp_in_valid, // Sample in strobe
    input wire cvmc_pkg::cvmc_chan_t smp_in_chan, // Sample in channel
    input wire logic smp_out_valid, // Sample out strobe
    input wire cvmc_pkg::cvmc_chan_t smp_out_chan, // Sample out channel
    input wire logic [5:0] slot_bclk_cycles, // Slot width
    input wire logic [8:0] osr_ratio, // Oversampling ratio
    input wire logic deemphasis_enable, // De-emphasis
    input wire logic output_polarity_invert, // Polarity
    input wire cvmc_pkg::cvmc_chmask_t chan_mute // Mutes
);
    import cvmc_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // Register port
    rvalid_follow_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read strobe not answered");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read valid without a read");
    rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
        else $error("read data not zero while idle");
    reset_val_a: assert property ($rose(rst_b) |-> slot_bclk_cycles == 6'h20
        && osr_ratio == 9'h080 && chan_mute == 12'h000)
        else $error("wrong values after reset");
    // ==========================================================
    // Derived settings, two edges after a control write; samples one edge after input
    slot_width_a: assert property (reg_wr && reg_addr == 8'h08 |=> ##1
        slot_bclk_cycles == ($past(reg_wdata[4], 2) ? 6'h10 : 6'h20))
        else $error("slot width does not follow control");
    osr_sel_a: assert property (reg_wr && reg_addr == 8'h08 |=> ##1
        osr_ratio == ($past(reg_wdata[1], 2) ? 9'h080 : 9'h100))
        else $error("oversampling does not follow control");
    pol_sel_a: assert property (reg_wr && reg_addr == 8'h08 |-> ##2
        output_polarity_invert == $past(reg_wdata[3], 2))
        else $error("polarity does not follow control");
    deemph_sel_a: assert property (reg_wr && reg_addr == 8'h08 |-> ##2
        deemphasis_enable == $past(reg_wdata[0], 2))
        else $error("de-emphasis does not follow control");
    smp_lat_a: assert property (smp_in_valid |=> smp_out_valid
        && smp_out_chan == $past(smp_in_chan))
        else $error("sample not passed one cycle later");
endmodule

/* File: test/cvmc_host.sv */
// Host model: issues single byte register accesses.
// Assumes the bank answers a read one cycle after the read edge.
`timescale 1ns/10ps
module cvmc_host (
    input wire logic sys_clk, // Clock
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output cvmc_pkg::cvmc_byte_t reg_addr, // Address
    output cvmc_pkg::cvmc_byte_t reg_wdata, // Write data
    input wire cvmc_pkg::cvmc_byte_t reg_rdata, // Read data
    input wire logic reg_rvalid // Read valid
);
    import cvmc_pkg::*;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input cvmc_byte_t a, input cvmc_byte_t d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Bounded wait, so a silent bank cannot hang the run
    task automatic rd(input cvmc_byte_t a, output cvmc_byte_t d, output logic ok);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata;
            end else begin
                @(posedge sys_clk);
            end
        end
    endtask
endmodule

/* File: test/channel_volume_mute_control_bench.sv */
// Self-checking bench of the volume and mute control bank.
// Assumes cvmc_top, cvmc_host and cvmc_sva are compiled first.
`timescale 1ns/10ps
module channel_volume_mute_control_bench;
    import cvmc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid, smp_in_valid, smp_out_valid;
    logic deemphasis_enable, output_polarity_invert;
    cvmc_byte_t reg_addr, reg_wdata, reg_rdata, master_atten;
    cvmc_byte_t ch1_eff_atten, ch2_eff_atten, ch3_eff_atten;
    cvmc_chan_t smp_in_chan, smp_out_chan;
    cvmc_sample_t smp_in_data, smp_out_data;
    cvmc_chmask_t chan_mute;
    logic [5:0] slot_bclk_cycles;
    logic [8:0] osr_ratio;
    int fails = 0;
    int n_compared = 0;
    always #4 sys_clk = ~sys_clk;
    cvmc_top i_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .smp_in_valid(smp_in_valid), .smp_in_chan(smp_in_chan),
        .smp_in_data(smp_in_data), .smp_out_valid(smp_out_valid),
        .smp_out_chan(smp_out_chan), .smp_out_data(smp_out_data),
        .slot_bclk_cycles(slot_bclk_cycles), .osr_ratio(osr_ratio),
        .deemphasis_enable(deemphasis_enable),
        .output_polarity_invert(output_polarity_invert), .chan_mute(chan_mute),
        .master_atten(master_atten), .ch1_eff_atten(ch1_eff_atten),
        .ch2_eff_atten(ch2_eff_atten), .ch3_eff_atten(ch3_eff_atten)
    );
    cvmc_host i_host (
        .sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
    );
    // ==========================================================
    // Shared tasks
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input cvmc_byte_t a, input cvmc_byte_t exp);
        cvmc_byte_t d;
        logic ok;
        i_host.rd(a, d, ok);
        if (!ok) begin
            fails++;
            $display("MISMATCH t=%0t no read answer at %h", $time, a);
            finish_test();
        end else begin
            chk(d, exp);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic smp(input cvmc_chan_t ch, input cvmc_sample_t d, input cvmc_sample_t e);
        @(posedge sys_clk);
        smp_in_valid <= 1'b1;
        smp_in_chan <= ch;
        smp_in_data <= d;
        @(posedge sys_clk);
        smp_in_valid <= 1'b0;
        #1;
        chk(smp_out_valid, 1);
        chk(smp_out_data, e);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        cvmc_byte_t rv [9] = '{8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        cvmc_byte_t fv [9] = '{8'h00, 8'h1f, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
        for (int i = 0; i < 9; i++) rdchk(8'(8'h07 + i), rv[i]);
        for (int i = 0; i < 9; i++) i_host.wr(8'(8'h07 + i), 8'hff);
        for (int i = 0; i < 9; i++) rdchk(8'(8'h07 + i), fv[i]);
        settle();
        chk({slot_bclk_cycles, osr_ratio}, {6'h10, 9'h080});
        chk({output_polarity_invert, deemphasis_enable}, 2'b11);
        chk(chan_mute, 12'hfff);
        for (int i = 0; i < 9; i++) i_host.wr(8'(8'h07 + i), 8'h00);
        settle();
        chk({slot_bclk_cycles, osr_ratio}, {6'h20, 9'h100});
        chk({output_polarity_invert, deemphasis_enable, chan_mute}, 14'h0);
    endtask
    task automatic t_pol();
        i_host.wr(8'h08, 8'h08);
        settle();
        smp(4'h0, 24'h000005, 24'hfffffb);
        smp(4'h1, 24'h800000, 24'h7fffff);
        i_host.wr(8'h08, 8'h00);
        settle();
        smp(4'h0, 24'h000005, 24'h000005);
    endtask
    task automatic t_mute();
        i_host.wr(8'h09, 8'h81);
        i_host.wr(8'h0a, 8'h08);
        settle();
        chk(chan_mute, 12'h881);
        smp(4'h0, 24'h000005, 24'h0);
        smp(4'h7, 24'h000005, 24'h0);
        smp(4'hb, 24'h000005, 24'h0);
        smp(4'h8, 24'h000005, 24'h000005);
        i_host.wr(8'h09, 8'h00);
        i_host.wr(8'h0a, 8'h00);
    endtask
    task automatic t_att();
        i_host.wr(8'h0b, 8'h10);
        i_host.wr(8'h0c, 8'h20);
        i_host.wr(8'h0d, 8'hf0);
        settle();
        chk({master_atten, ch1_eff_atten}, 16'h1030);
        chk({ch2_eff_atten, ch3_eff_atten}, 16'hff10);
        chk(chan_mute, 12'h002);
        i_host.wr(8'h0b, 8'h00);
        i_host.wr(8'h0c, 8'h00);
        i_host.wr(8'h0d, 8'h00);
    endtask
    task automatic t_auto();
        i_host.wr(8'h08, 8'h04);
        @(posedge sys_clk);
        smp_in_valid <= 1'b1;
        smp_in_chan <= 4'h2;
        smp_in_data <= '0;
        repeat (1023) @(posedge sys_clk);
        smp_in_valid <= 1'b0;
        settle();
        chk(chan_mute, 12'h000);
        smp(4'h2, 24'h0, 24'h0);
        settle();
        chk(chan_mute, 12'h004);
        // The sample that breaks the run still meets the registered automute
        smp(4'h2, 24'h000007, 24'h000000);
        settle();
        chk(chan_mute, 12'h000);
    endtask
    task automatic t_reset();
        i_host.wr(8'h08, 8'h1f);
        i_host.wr(8'h0b, 8'h55);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rdchk(8'h08, 8'h06);
        rdchk(8'h0b, 8'h00);
        chk({slot_bclk_cycles, osr_ratio, master_atten}, {6'h20, 9'h080, 8'h00});
    endtask
    initial begin
        smp_in_valid = 1'b0;
        smp_in_chan = '0;
        smp_in_data = '0;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_regs();
        t_pol();
        t_mute();
        t_att();
        t_auto();
        t_reset();
        finish_test();
    end
endmodule
bind cvmc_top cvmc_sva i_sva (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .smp_in_valid(smp_in_valid), .smp_in_chan(smp_in_chan),
    .smp_out_valid(smp_out_valid), .smp_out_chan(smp_out_chan),
    .slot_bclk_cycles(slot_bclk_cycles), .osr_ratio(osr_ratio),
    .deemphasis_enable(deemphasis_enable),
    .output_polarity_invert(output_polarity_invert), .chan_mute(chan_mute)
);
